// ### design/hlpl_map.vh
// Purpose: Constants for the lane I/O block, register map and timing.
// Assumes: 32-bit AHB-Lite register bus, 40 MHz hclk.
// Notes: Included by every design file of the lane block.
//
// Notes on behaviour
// - Receive lane presents each deserialized byte at the RXBYTE register unless the buffer is full.
// - Clock lane derives serial and parallel clocks for its data lanes.
// - Clock lane also produces its incoming clock divided by four.
// - Parallel and serial clock feeds go to both the receive and the transmit shifter.
// - With buffer enabled, rx_buffer_drained is high whenever buffer is empty.
// - Receive reset clears buffer and deserializer synchronously.
// - With delay_step_enable, delay steps up on delay_step_up, else down.
// - delay_tap_clear returns the delay counter to its initial setting.
// - fast_receiver_enable switches the high-speed input buffer.
// - fast_termination_enable switches the high-speed termination.
// - Receive lane drives low-power pads only when configured reversible.
// - Receive lane passes sampled P and N low-power levels to fabric.
// - In transmit mode clocks come from one common clock source.
// - Transmit reset clears the serializer.
// - Transmit lane returns pad levels whether or not configured reversible.
// - High-speed mode serializes by eight; low-power mode passes levels.
// - Receive parallel clock is the incoming clock divided down.
`ifndef HLPL_MAP_VH
`define HLPL_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HLPL_OFF_CTRL      8'h00
`define HLPL_OFF_STATUS    8'h04
`define HLPL_OFF_TXBYTE    8'h08
`define HLPL_OFF_RXBYTE    8'h0C
`define HLPL_OFF_DELAY     8'h10
`define HLPL_OFF_LPDRV     8'h14

// ****************************************************************
// Control fields
// ****************************************************************
`define HLPL_CTRL_RXEN     0
`define HLPL_CTRL_TERM     1
`define HLPL_CTRL_HSOE     2
`define HLPL_CTRL_REV      3
`define HLPL_CTRL_BUFEN    4
`define HLPL_CTRL_RXRST    5
`define HLPL_CTRL_TXRST    6
`define HLPL_CTRL_RESET    7'h00

// ****************************************************************
// Delay command fields and limits
// ****************************************************************
`define HLPL_DELAY_STEP_ENABLE       0
`define HLPL_DELAY_STEP_UP       1
`define HLPL_DLY_CLR       2
`define HLPL_DLY_INIT      6'h00
`define HLPL_DLY_MAX       6'h3F

// ****************************************************************
// Lane framing
// ****************************************************************
`define HLPL_SER_FACTOR    3'h7
`define HLPL_DIV_LAST      2'h3

`endif

// ### design/hlpl_clock_lane.v
// Purpose: Clock lane that derives parallel and quarter clocks from a lane.
// Assumes: The incoming serial clock is sampled as an enable on hclk.
// Notes: Outputs are enable strobes, one hclk wide.
`timescale 1ns/1ps
`include "hlpl_map.vh"
module hlpl_clock_lane (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       serial_clock,
    output reg        parallel_strobe,
    output reg        quarter_strobe
);
    reg [2:0] bit_cnt_reg;
    reg [1:0] div_cnt_reg;

    // The serial clock is a per-bit strobe here; eight bits form one
    // parallel period, and every fourth serial tick gives the quarter clock.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_reg     <= 3'h0;
            div_cnt_reg     <= 2'h0;
            parallel_strobe <= 1'b0;
            quarter_strobe  <= 1'b0;
        end else begin
            parallel_strobe <= 1'b0;
            quarter_strobe  <= 1'b0;
            if (serial_clock) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                div_cnt_reg <= div_cnt_reg + 2'h1;
                parallel_strobe <= (bit_cnt_reg == `HLPL_SER_FACTOR);
                quarter_strobe  <= (div_cnt_reg == `HLPL_DIV_LAST);
            end
        end
    end
endmodule // hlpl_clock_lane

// ### design/hlpl_deser.v
// Purpose: One-to-eight shifter for receive and eight-to-one for transmit.
// Assumes: bit_strobe marks one serial bit; byte_strobe marks byte ends.
// Notes: A clear drops any partial byte; byte ends stay with the clock lane count.
`timescale 1ns/1ps
`include "hlpl_map.vh"
module hlpl_deser #(
    parameter WIDTH = 8
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             clear,
    input  wire             bit_strobe,
    input  wire             byte_strobe,
    input  wire             rx_bit,
    input  wire [WIDTH-1:0] tx_load,
    output reg  [WIDTH-1:0] rx_byte,
    output reg              rx_valid,
    output wire             tx_bit
);
    reg [WIDTH-1:0] rx_shift_reg;
    reg [WIDTH-1:0] tx_shift_reg;

    assign tx_bit = tx_shift_reg[WIDTH-1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_shift_reg <= {WIDTH{1'b0}};
            tx_shift_reg <= {WIDTH{1'b0}};
            rx_byte      <= {WIDTH{1'b0}};
            rx_valid     <= 1'b0;
        end else if (clear) begin
            rx_shift_reg <= {WIDTH{1'b0}};
            tx_shift_reg <= {WIDTH{1'b0}};
            rx_valid     <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (bit_strobe) begin
                rx_shift_reg <= {rx_shift_reg[WIDTH-2:0], rx_bit};
                tx_shift_reg <= {tx_shift_reg[WIDTH-2:0], 1'b0};
            end
            if (byte_strobe) begin
                // The byte strobe trails the last bit by one cycle, so the
                // shifter already holds the whole byte; the line has moved on.
                rx_byte      <= rx_shift_reg;
                rx_valid     <= 1'b1;
                tx_shift_reg <= tx_load;
            end
        end
    end
endmodule // hlpl_deser

// ### design/hlpl_lane_top.v
// Purpose: One configurable high-speed / low-power lane behind AHB-Lite.
// Assumes: Serial bits arrive as strobes on hclk; pads are split signals.
// Notes: A small receive buffer sits between deserializer and fabric.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "hlpl_map.vh"
module hlpl_lane_top #(
    parameter BUF_DEPTH_LOG = 2
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        serial_clock,
    input  wire        rx_serial_bit,
    output reg         tx_serial_bit,
    output reg         fast_drive_enable,
    output reg         fast_receiver_enable,
    output reg         fast_termination_enable,
    input  wire        pad_pos_in,
    input  wire        pad_neg_in,
    output reg         lowpower_pos_drive_level,
    output reg         lowpower_pos_drive_enable_n,
    output reg         lowpower_neg_drive_level,
    output reg         lowpower_neg_drive_enable_n,
    output reg         lowpower_pos_sense,
    output reg         lowpower_neg_sense,
    output reg         lane_divided_core_clock,
    output reg         lane_parallel_clock_feed,
    output reg         rx_buffer_drained
);
    localparam DEPTH = 1 << BUF_DEPTH_LOG;
    localparam [BUF_DEPTH_LOG:0] PTR_ONE = {{BUF_DEPTH_LOG{1'b0}}, 1'b1};

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [6:0]  ctrl_reg;
    reg [7:0]  tx_byte_reg;
    reg [5:0]  delay_tap_reg;
    reg [3:0]  lp_drive_reg;
    reg        wr_pend_reg;
    reg [7:0]  wr_addr_reg;
    reg [7:0]  last_rx_reg;
    reg        quarter_reg;
    reg [7:0]  buf_mem [0:DEPTH-1];
    reg [BUF_DEPTH_LOG:0] wr_ptr_reg;
    reg [BUF_DEPTH_LOG:0] rd_ptr_reg;

    wire       parallel_strobe;
    wire       quarter_strobe;
    wire [7:0] rx_byte;
    wire       rx_valid;
    wire       tx_bit;
    wire       reversible = ctrl_reg[`HLPL_CTRL_REV];
    wire       buf_en     = ctrl_reg[`HLPL_CTRL_BUFEN];
    wire       lane_clear = ctrl_reg[`HLPL_CTRL_RXRST] |
                            ctrl_reg[`HLPL_CTRL_TXRST];
    wire       addr_ok    = hsel & hready & htrans[1];
    wire       buf_empty  = (wr_ptr_reg == rd_ptr_reg);
    wire       buf_full   = (wr_ptr_reg[BUF_DEPTH_LOG] !=
                             rd_ptr_reg[BUF_DEPTH_LOG]) &&
                            (wr_ptr_reg[BUF_DEPTH_LOG-1:0] ==
                             rd_ptr_reg[BUF_DEPTH_LOG-1:0]);
    wire       rd_rx      = addr_ok & ~hwrite &
                            (haddr[7:0] == `HLPL_OFF_RXBYTE);
    wire       pop        = rd_rx & buf_en & ~buf_empty;
    wire       delay_wr   = wr_pend_reg &
                            (wr_addr_reg == `HLPL_OFF_DELAY);

    // ****************************************************************
    // Clock lane and shifter
    // ****************************************************************
    hlpl_clock_lane u_clk (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .serial_clock    (serial_clock),
        .parallel_strobe (parallel_strobe),
        .quarter_strobe  (quarter_strobe)
    );

    hlpl_deser #(.WIDTH(8)) u_shift (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .clear       (lane_clear),
        .bit_strobe  (serial_clock),
        .byte_strobe (parallel_strobe),
        .rx_bit      (rx_serial_bit),
        .tx_load     (tx_byte_reg),
        .rx_byte     (rx_byte),
        .rx_valid    (rx_valid),
        .tx_bit      (tx_bit)
    );

    // ****************************************************************
    // Bus slave: writes land in the data phase, reads answer at once
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            wr_addr_reg <= haddr[7:0];
            hrdata      <= 32'h00000000;
            if (addr_ok & ~hwrite) begin
                case (haddr[7:0])
                    `HLPL_OFF_CTRL:   hrdata <= {25'h0000000, ctrl_reg};
                    `HLPL_OFF_STATUS: hrdata <= {29'h00000000, buf_full,
                                                 pad_neg_in, pad_pos_in};
                    `HLPL_OFF_TXBYTE: hrdata <= {24'h000000, tx_byte_reg};
                    `HLPL_OFF_RXBYTE: hrdata <= {24'h000000,
                        buf_en ? buf_mem[rd_ptr_reg[BUF_DEPTH_LOG-1:0]]
                               : last_rx_reg};
                    `HLPL_OFF_DELAY:  hrdata <= {26'h0000000, delay_tap_reg};
                    `HLPL_OFF_LPDRV:  hrdata <= {28'h0000000, lp_drive_reg};
                    default:          hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg     <= `HLPL_CTRL_RESET;
            tx_byte_reg  <= 8'h00;
            lp_drive_reg <= 4'h0;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                `HLPL_OFF_CTRL:   ctrl_reg     <= hwdata[6:0];
                `HLPL_OFF_TXBYTE: tx_byte_reg  <= hwdata[7:0];
                `HLPL_OFF_LPDRV:  lp_drive_reg <= hwdata[3:0];
                default:          ctrl_reg     <= ctrl_reg;
            endcase
        end
    end

    // ****************************************************************
    // Input delay tap, stepped once per write to the DELAY register
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_tap_reg <= `HLPL_DLY_INIT;
        end else if (delay_wr & hwdata[`HLPL_DLY_CLR]) begin
            delay_tap_reg <= `HLPL_DLY_INIT;
        end else if (delay_wr & hwdata[`HLPL_DELAY_STEP_ENABLE]) begin
            if (hwdata[`HLPL_DELAY_STEP_UP]) begin
                if (delay_tap_reg != `HLPL_DLY_MAX)
                    delay_tap_reg <= delay_tap_reg + 6'h01;
            end else if (delay_tap_reg != `HLPL_DLY_INIT) begin
                delay_tap_reg <= delay_tap_reg - 6'h01;
            end
        end
    end

    // ****************************************************************
    // Receive buffer; the receive reset empties it
    // ****************************************************************
    always @(posedge hclk) begin
        if (rx_valid & buf_en & ~buf_full)
            buf_mem[wr_ptr_reg[BUF_DEPTH_LOG-1:0]] <= rx_byte;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg  <= {(BUF_DEPTH_LOG+1){1'b0}};
            rd_ptr_reg  <= {(BUF_DEPTH_LOG+1){1'b0}};
            last_rx_reg <= 8'h00;
        end else if (ctrl_reg[`HLPL_CTRL_RXRST]) begin
            wr_ptr_reg <= {(BUF_DEPTH_LOG+1){1'b0}};
            rd_ptr_reg <= {(BUF_DEPTH_LOG+1){1'b0}};
        end else begin
            // A full buffer drops the new byte; the lane cannot stall.
            if (rx_valid & buf_en & ~buf_full)
                wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
            if (rx_valid)
                last_rx_reg <= rx_byte;
        end
    end

    // ****************************************************************
    // Pad-side and clock outputs, all registered
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_serial_bit               <= 1'b0;
            fast_drive_enable           <= 1'b0;
            fast_receiver_enable        <= 1'b0;
            fast_termination_enable     <= 1'b0;
            lowpower_pos_drive_level    <= 1'b0;
            lowpower_pos_drive_enable_n <= 1'b1;
            lowpower_neg_drive_level    <= 1'b0;
            lowpower_neg_drive_enable_n <= 1'b1;
            lowpower_pos_sense          <= 1'b0;
            lowpower_neg_sense          <= 1'b0;
            quarter_reg                 <= 1'b0;
            lane_divided_core_clock     <= 1'b0;
            lane_parallel_clock_feed    <= 1'b0;
            rx_buffer_drained           <= 1'b1;
        end else begin
            tx_serial_bit <= tx_bit & ctrl_reg[`HLPL_CTRL_HSOE];
            fast_drive_enable <= ctrl_reg[`HLPL_CTRL_HSOE];
            fast_receiver_enable <= ctrl_reg[`HLPL_CTRL_RXEN];
            fast_termination_enable <= ctrl_reg[`HLPL_CTRL_TERM];
            lowpower_pos_drive_level    <= lp_drive_reg[1];
            lowpower_neg_drive_level    <= lp_drive_reg[3];
            lowpower_pos_drive_enable_n <= ~(reversible & lp_drive_reg[0]);
            lowpower_neg_drive_enable_n <= ~(reversible & lp_drive_reg[2]);
            lowpower_pos_sense <= pad_pos_in;
            lowpower_neg_sense <= pad_neg_in;
            if (quarter_strobe)
                quarter_reg <= ~quarter_reg;
            lane_divided_core_clock  <= quarter_reg;
            lane_parallel_clock_feed <= parallel_strobe;
            rx_buffer_drained <= buf_empty | ~buf_en;
        end
    end
endmodule // hlpl_lane_top

// ### bench/hlpl_lane_chk.sv
// Purpose: Port assertions for the lane block.
// Assumes: One hclk domain; hresetn is asynchronous, active low.
// Notes: Strobe windows of one either side absorb fixed pipeline latency.
`timescale 1ns/1ps
`include "hlpl_map.vh"
module hlpl_lane_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        serial_clock,
    input wire logic        pad_pos_in,
    input wire logic        pad_neg_in,
    input wire logic        tx_serial_bit,
    input wire logic        fast_drive_enable,
    input wire logic        fast_receiver_enable,
    input wire logic        fast_termination_enable,
    input wire logic        lowpower_pos_sense,
    input wire logic        lowpower_neg_sense,
    input wire logic        lane_divided_core_clock,
    input wire logic        lane_parallel_clock_feed,
    input wire logic        rx_buffer_drained
);
    // ****************
    // Helper counters
    // ****************
    logic [3:0] feed_gap_reg, div_gap_reg;
    logic [2:0] since_feed_reg, hw_low;
    logic [1:0] pad_pair;
    logic       feed_seen_reg, div_seen_reg, div_prev_reg, div_toggle;
    assign div_toggle = lane_divided_core_clock != div_prev_reg;
    assign hw_low = hwdata[2:0];
    assign pad_pair = {pad_neg_in, pad_pos_in};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // The first event after reset has no earlier event to measure from.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feed_gap_reg <= 4'h0;
            div_gap_reg <= 4'h0;
            since_feed_reg <= 3'h7;
            feed_seen_reg <= 1'h0;
            div_seen_reg <= 1'h0;
            div_prev_reg <= 1'h0;
        end else begin
            feed_gap_reg <= (lane_parallel_clock_feed ? 4'h0 : feed_gap_reg)
                            + {3'h0, serial_clock};
            div_gap_reg <= (div_toggle ? 4'h0 : div_gap_reg)
                           + {3'h0, serial_clock};
            since_feed_reg <= lane_parallel_clock_feed ? 3'h0 :
                              since_feed_reg + {2'h0, since_feed_reg != 3'h7};
            feed_seen_reg <= feed_seen_reg | lane_parallel_clock_feed;
            div_seen_reg <= div_seen_reg | div_toggle;
            div_prev_reg <= lane_divided_core_clock;
        end
    end
    // ****************
    // Assertions
    // ****************
    sequence s_ctrl_write;
        hsel && hready && htrans[1] && hwrite && haddr == 32'h0 ##1 1'h1;
    endsequence
    sequence s_strobe_recent;
        $past(serial_clock) || $past(serial_clock, 2) || $past(serial_clock, 3);
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer is not ready and OKAY");
    AST_CTRL_LEVELS: assert property (
        s_ctrl_write |=> ##1 {fast_drive_enable, fast_termination_enable,
        fast_receiver_enable} == $past(hw_low, 2))
        else $error("lane levels do not follow the control word");
    AST_FEED_PULSE: assert property (
        lane_parallel_clock_feed |=> !lane_parallel_clock_feed)
        else $error("parallel feed pulse is wider than one cycle");
    AST_FEED_SPACING: assert property (
        lane_parallel_clock_feed && feed_seen_reg |->
        feed_gap_reg >= 4'h7 && feed_gap_reg <= 4'h9)
        else $error("parallel feed not every eight strobes");
    AST_DIV_SPACING: assert property (
        div_toggle && div_seen_reg |-> div_gap_reg >= 4'h3 && div_gap_reg <= 4'h5)
        else $error("divided clock not toggling every four strobes");
    AST_SENSE: assert property (
        {lowpower_neg_sense, lowpower_pos_sense} == $past(pad_pair))
        else $error("pad sense does not follow the pads");
    AST_TX_GATE: assert property (
        !fast_drive_enable && !$past(fast_drive_enable) |-> !tx_serial_bit)
        else $error("serial output active while drive is off");
    AST_TX_ON_STROBE: assert property (
        $changed(tx_serial_bit) && fast_drive_enable &&
        $past(fast_drive_enable, 3) |-> s_strobe_recent)
        else $error("serial output moved without a bit strobe");
    AST_DRAIN_FALL: assert property (
        $fell(rx_buffer_drained) |-> since_feed_reg <= 3'h6)
        else $error("buffer left empty without a new byte");
endmodule // hlpl_lane_chk

bind hlpl_lane_top hlpl_lane_chk u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .serial_clock, .pad_pos_in, .pad_neg_in,
    .tx_serial_bit, .fast_drive_enable, .fast_receiver_enable,
    .fast_termination_enable, .lowpower_pos_sense, .lowpower_neg_sense,
    .lane_divided_core_clock, .lane_parallel_clock_feed, .rx_buffer_drained
);

// ### bench/hlpl_line_src.sv
// Purpose: Line side of the lane: bit strobes, serial data, pad levels.
// Assumes: Strobes are one hclk wide; bits travel first bit first.
// Notes: The strobe stands still outside frames.
`timescale 1ns/1ps
module hlpl_line_src (
    input  wire logic hclk,
    output logic      serial_clock,
    output logic      rx_serial_bit,
    output logic      pad_pos_in,
    output logic      pad_neg_in
);
    initial begin
        serial_clock = 1'h0;
        rx_serial_bit = 1'h0;
        pad_pos_in = 1'h0;
        pad_neg_in = 1'h0;
    end
    // The data line flips after each bit so a stale bit is never reused.
    task automatic send(input logic [7:0] v, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            serial_clock <= 1'h1;
            rx_serial_bit <= v[7 - i];
            @(posedge hclk);
            serial_clock <= 1'h0;
            rx_serial_bit <= ~v[7 - i];
            repeat (gap + 1) @(posedge hclk);
        end
    endtask
    task automatic pads(input logic p, input logic n);
        pad_pos_in <= p;
        pad_neg_in <= n;
    endtask
endmodule // hlpl_line_src

// ### bench/tb_hs_lp_phy_lane_io.sv
// Purpose: Self-checking bench for the lane block behind AHB-Lite.
// Assumes: The bench is the fabric master; hlpl_line_src drives the line.
// Notes: Queue and integer models predict bytes, counts and the delay tap.
`timescale 1ns/1ps
`include "hlpl_map.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_hs_lp_phy_lane_io;
    localparam int DEPTH_LOG = 2;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, c;
    logic [7:0]  v, t, tx_sh;
    logic [7:0]  q[$];
    logic        div_q = 1'h0, sc_q = 1'h0, r, pp, pn;
    int          error_cnt = 0, checks = 0;
    int          feed_n = 0, div_n = 0, strobes = 0, tap = 0;
    wire [31:0]  hrdata;
    wire hreadyout, hresp, hready, serial_clock, rx_serial_bit, pad_pos_in;
    wire pad_neg_in, tx_serial_bit, fast_drive_enable, fast_receiver_enable;
    wire fast_termination_enable, lowpower_pos_drive_level;
    wire lowpower_pos_drive_enable_n, lowpower_neg_drive_level;
    wire lowpower_neg_drive_enable_n, lowpower_pos_sense, lowpower_neg_sense;
    wire lane_divided_core_clock, lane_parallel_clock_feed, rx_buffer_drained;
    wire [3:0] lp_out = {lowpower_neg_drive_level, lowpower_neg_drive_enable_n,
                         lowpower_pos_drive_level, lowpower_pos_drive_enable_n};
    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;
    hlpl_lane_top #(.BUF_DEPTH_LOG(DEPTH_LOG)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .serial_clock, .rx_serial_bit,
        .tx_serial_bit, .fast_drive_enable, .fast_receiver_enable,
        .fast_termination_enable, .pad_pos_in, .pad_neg_in,
        .lowpower_pos_drive_level, .lowpower_pos_drive_enable_n,
        .lowpower_neg_drive_level, .lowpower_neg_drive_enable_n,
        .lowpower_pos_sense, .lowpower_neg_sense, .lane_divided_core_clock,
        .lane_parallel_clock_feed, .rx_buffer_drained);
    hlpl_line_src src (.hclk, .serial_clock, .rx_serial_bit, .pad_pos_in,
                       .pad_neg_in);
    // ****************
    // Bus and verdict
    // ****************
    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'h1 && k < 64);
        if (k >= 64) begin
            `CHK("hreadyout", 1'h1, hreadyout)
            print_verdict;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    always @(posedge hclk) begin
        if (hresetn) begin
            feed_n += (lane_parallel_clock_feed === 1'h1);
            div_n += (lane_divided_core_clock !== div_q);
            strobes += (serial_clock === 1'h1);
        end
        // A sent bit is registered on its strobe, so read it one edge later.
        if (sc_q) tx_sh = {tx_sh[6:0], tx_serial_bit};
        sc_q = serial_clock;
        div_q = lane_divided_core_clock;
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        void'($urandom(76435));
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        `CHK("drained", 1'h1, rx_buffer_drained)
        `CHK("en_n", 2'h3, {lp_out[2], lp_out[0]})
        for (int b = 0; b < 3; b++) begin
            bus(1'h1, `HLPL_OFF_CTRL, 32'h1 << b);
            repeat (2) @(posedge hclk);
            `CHK("rx_en", b == 0, fast_receiver_enable)
            `CHK("term", b == 1, fast_termination_enable)
            `CHK("fast_drive_enable", b == 2, fast_drive_enable)
        end
        t = 8'($urandom);
        bus(1'h1, `HLPL_OFF_TXBYTE, {24'h0, t});
        bus(1'h1, `HLPL_OFF_CTRL, 32'h17);
        for (int i = 0; i < 5; i++) begin
            v = 8'($urandom);
            src.send(v, 8, i % 3);
            if (q.size() < (1 << DEPTH_LOG)) q.push_back(v);
        end
        `CHK("tx_byte", t, tx_sh)
        repeat (4) @(posedge hclk);
        `CHK("drained", 1'h0, rx_buffer_drained)
        bus(1'h0, `HLPL_OFF_STATUS, 32'h0);
        `CHK("full", 1'h1, rd[2])
        while (q.size() > 0) begin
            bus(1'h0, `HLPL_OFF_RXBYTE, 32'h0);
            v = q.pop_front();
            `CHK("rx_byte", v, rd[7:0])
        end
        repeat (2) @(posedge hclk);
        `CHK("drained", 1'h1, rx_buffer_drained)
        src.send(8'hE0, 3, 0);
        bus(1'h1, `HLPL_OFF_CTRL, 32'h73);
        src.send(8'h1F, 5, 1);
        bus(1'h1, `HLPL_OFF_CTRL, 32'h17);
        v = 8'($urandom);
        src.send(v, 8, 0);
        repeat (4) @(posedge hclk);
        `CHK("tx_after_rst", 8'h00, tx_sh)
        bus(1'h0, `HLPL_OFF_RXBYTE, 32'h0);
        `CHK("rx_after_rst", v, rd[7:0])
        repeat (2) @(posedge hclk);
        `CHK("drained", 1'h1, rx_buffer_drained)
        for (int i = 0; i < 90; i++) begin
            c = (i < 70) ? 3'h3 : (i == 70) ? 3'h4 : (i == 71) ? 3'h1 :
                3'($urandom);
            if (c[2]) tap = 0;
            else if (c[0] && c[1]) tap = (tap < 63) ? tap + 1 : 63;
            else if (c[0]) tap = (tap > 0) ? tap - 1 : 0;
            bus(1'h1, `HLPL_OFF_DELAY, {29'h0, c});
            bus(1'h0, `HLPL_OFF_DELAY, 32'h0);
            `CHK("tap", tap[5:0], rd[5:0])
        end
        for (int i = 0; i < 32; i++) begin
            r = i[4];
            {pn, pp} = 2'($urandom);
            bus(1'h1, `HLPL_OFF_CTRL, {28'h1, r, 3'h7});
            bus(1'h1, `HLPL_OFF_LPDRV, {28'h0, 4'(i)});
            src.pads(pp, pn);
            repeat (3) @(posedge hclk);
            `CHK("lp", {i[3], ~(r & i[2]), i[1], ~(r & i[0])}, lp_out)
            `CHK("sense", {pn, pp}, {lowpower_neg_sense, lowpower_pos_sense})
            bus(1'h0, `HLPL_OFF_STATUS, 32'h0);
            `CHK("status", {pn, pp}, rd[1:0])
        end
        `CHK("strobes", 56, strobes)
        `CHK("feed", strobes / 8, feed_n)
        `CHK("div", strobes / 4, div_n)
        print_verdict;
    end
endmodule // tb_hs_lp_phy_lane_io
